// ---- design/npx_regs.sv ----
// Partner next-page register and extended control register with management access.
//
// Contract
// - Partner next-page register at address 0x08, 16 bits, read-only, resets to zero.
// - Bit 15 reports more pages: zero last page, one more follow.
// - Bit 14 of the partner register always reads zero.
// - Bit 13 reports page format: zero unformatted, one message page.
// - Bit 12 reports second acknowledge: zero cannot comply, one can comply.
// - Toggle bit 11 alternates between successive next-page words.
// - First next-page toggle equals inverse of base word bit 11.
// - Bits 10..0 hold the 11-bit message or unformatted code field.
// - Extended control at 0x10, bit 15 self-clearing override enable, reset zero.
// - Bits 14..11, 4 and 1 are writable reserved, written as zero.
// - Bits 10..6 are read-only address bits latched from straps at reset.
// - Bit 5 selects scrambler test mode, read-write, resets zero.
// - Override enable lets the next write alter protected bits, then clears.
// - Bit 3 selects NRZ (zero) or NRZI (one), resets to one.
// - Bit 2 with transmit error forces invalid-code nibble translation.
// - Bit 0 disables scrambler and descrambler, resets zero.
`timescale 1ns/1ps
`include "npx_params.svh"

module npx_regs
(
  input  wire logic               clk,
  input  wire logic               arst_n,
  // Management port, one access per strobe.
  input  wire logic               mgmtWrite,
  input  wire logic               mgmtRead,
  input  wire logic [4:0]         mgmtAddr,
  input  wire logic [15:0]        mgmtWdata,
  output logic      [15:0]        mgmtRdata,
  output logic                    mgmtRvalid,
  // Auto-negotiation side.
  input  wire logic               pageValid,
  input  wire npx_pkg::npx_page_t pageIn,
  input  wire logic               baseWordBit11,
  input  wire logic               negRestart,
  output logic                    expectedToggle,
  output logic                    overrideProtectedBits,
  // Strap pins.
  input  wire logic               addr4_strap_pin,
  input  wire logic               addr3_strap_pin,
  input  wire logic               addr2_strap_pin,
  input  wire logic               addr1_strap_pin,
  input  wire logic               addr0_strap_pin,
  // Transmit path.
  input  wire logic               txErr,
  input  wire logic [3:0]         txNibble,
  output logic                    txForce,
  output logic      [4:0]         txForcedSymbol,
  output npx_pkg::npx_ctrl_t      datapathCtrl,
  output logic      [4:0]         phyAddr
);

  // ------------------------------------------------------------
  // Strap capture
  // ------------------------------------------------------------
  logic [4:0] strapMeta;
  logic [4:0] strapSync;
  logic [1:0] strapPhase;
  wire  [4:0] strapPins = {addr4_strap_pin, addr3_strap_pin, addr2_strap_pin,
                           addr1_strap_pin, addr0_strap_pin};

  // Straps come from pins, so two flops precede the latch taken after release.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      strapMeta <= 5'h00;
      strapSync <= 5'h00;
    end
    else
    begin
      strapMeta <= strapPins;
      strapSync <= strapMeta;
    end
  end

  // Latch once the synchroniser holds post-reset levels; later pin motion is ignored.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      strapPhase <= 2'h0;
      phyAddr    <= 5'h00;
    end
    else if (strapPhase != `NPX_STRAP_DONE_PHASE)
    begin
      strapPhase <= strapPhase + 2'h1;
      if (strapPhase == `NPX_STRAP_LATCH_PHASE)
        phyAddr <= strapSync;
    end
  end

  // ------------------------------------------------------------
  // Partner next-page register
  // ------------------------------------------------------------
  npx_pkg::npx_page_t partnerPage;
  logic               firstPage;

  // Each new page overwrites the last; nothing else writes it.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      partnerPage <= 15'(`NPX_PARTNER_RESET);
    else if (pageValid)
      partnerPage <= pageIn;
  end

  // Track which toggle the next page must carry, to flag out-of-sequence pages.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      firstPage <= 1'b1;
    else if (negRestart)
      firstPage <= 1'b1;
    else if (pageValid)
      firstPage <= 1'b0;
  end

  // First page expects inverse of base bit 11, later pages the inverse of the last.
  assign expectedToggle = firstPage ? ~baseWordBit11
                                    : ~partnerPage.toggle;

  // Bit 14 is not stored at all, so it cannot read other than zero.
  wire [15:0] partnerRead = {partnerPage.moreFlag,
                             1'b0,
                             partnerPage.msgFlag,
                             partnerPage.ackFlag,
                             partnerPage.toggle,
                             partnerPage.code};

  // ------------------------------------------------------------
  // Extended control register
  // ------------------------------------------------------------
  logic       ovrEnable;
  logic [3:0] rsvdHi;
  logic       rsvd4;
  logic       rsvd1;
  logic       scrTest;
  logic       nrzi;
  logic       invCode;
  logic       scrDisable;

  wire hitPartner = (mgmtAddr == `NPX_ADDR_PARTNER_NP);
  wire hitExt     = (mgmtAddr == `NPX_ADDR_EXT_CTRL);
  wire wrExt      = mgmtWrite & hitExt;

  // Override enable: any write consumes it; a write to this register may set it again.
  wire next_ovrEnable = mgmtWrite ? (wrExt & mgmtWdata[`NPX_EC_OVR_BIT]) : ovrEnable;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      ovrEnable <= 1'b0;
    else
      ovrEnable <= next_ovrEnable;
  end

  assign overrideProtectedBits = ovrEnable;

  // Writable fields; reserved bits are stored as written, software keeps them zero.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rsvdHi     <= `NPX_RSVD_HI_RESET;
      rsvd4      <= 1'b0;
      rsvd1      <= 1'b0;
      scrTest    <= 1'b0;
      nrzi       <= `NPX_NRZI_RESET;
      invCode    <= 1'b0;
      scrDisable <= 1'b0;
    end
    else if (wrExt)
    begin
      rsvdHi     <= mgmtWdata[`NPX_EC_RSVD_HI_MSB:`NPX_EC_RSVD_HI_LSB];
      rsvd4      <= mgmtWdata[`NPX_EC_RSVD4_BIT];
      rsvd1      <= mgmtWdata[`NPX_EC_RSVD1_BIT];
      scrTest    <= mgmtWdata[`NPX_EC_SCR_TEST_BIT];
      nrzi       <= mgmtWdata[`NPX_EC_NRZI_BIT];
      invCode    <= mgmtWdata[`NPX_EC_INV_CODE_BIT];
      scrDisable <= mgmtWdata[`NPX_EC_SCR_DIS_BIT];
    end
  end

  // Address field ignores writes; it follows the strap latch only.
  wire [15:0] extRead = {ovrEnable, rsvdHi, phyAddr,
                         scrTest, rsvd4, nrzi, invCode, rsvd1, scrDisable};

  assign datapathCtrl = '{scrTest: scrTest, nrzi: nrzi,
                          invCode: invCode, scrDisable: scrDisable};

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  // Unmapped addresses read as zero so a stray poll sees no garbage.
  wire [15:0] next_mgmtRdata = hitPartner ? partnerRead :
                               hitExt     ? extRead     : 16'h0000;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mgmtRdata  <= 16'h0000;
      mgmtRvalid <= 1'b0;
    end
    else
    begin
      mgmtRvalid <= mgmtRead;
      if (mgmtRead)
        mgmtRdata <= next_mgmtRdata;
    end
  end

  // ------------------------------------------------------------
  // Invalid-code transmit test
  // ------------------------------------------------------------
  logic [4:0] mappedSymbol;

  npx_invalid_code_map uMap
  (
    .nibble (txNibble),
    .symbol (mappedSymbol)
  );

  // Forcing is combinational with the nibble; the encoder picks the symbol when txForce is high.
  assign txForce        = invCode & txErr;
  assign txForcedSymbol = mappedSymbol;

endmodule

// ---- include/npx_params.svh ----
// Register map, field positions, reset values and encodings of the partner page and extended control block.
`ifndef NPX_PARAMS_SVH
`define NPX_PARAMS_SVH

// ------------------------------------------------------------
// Register addresses
// ------------------------------------------------------------
`define NPX_ADDR_PARTNER_NP   5'h08
`define NPX_ADDR_EXT_CTRL     5'h10

// ------------------------------------------------------------
// Partner next-page field positions
// ------------------------------------------------------------
`define NPX_NP_MORE_BIT       15
`define NPX_NP_RSVD_BIT       14
`define NPX_NP_MSG_BIT        13
`define NPX_NP_COMPLY_ACK_FLAG_BIT       12
`define NPX_NP_TOGGLE_BIT     11
`define NPX_NP_CODE_MSB       10
`define NPX_BASE_TOGGLE_BIT   11
`define NPX_PARTNER_RESET     16'h0000

// ------------------------------------------------------------
// Extended control field positions and reset values
// ------------------------------------------------------------
`define NPX_EC_OVR_BIT        15
`define NPX_EC_RSVD_HI_MSB    14
`define NPX_EC_RSVD_HI_LSB    11
`define NPX_EC_ADDR_MSB       10
`define NPX_EC_ADDR_LSB       6
`define NPX_EC_SCR_TEST_BIT   5
`define NPX_EC_RSVD4_BIT      4
`define NPX_EC_NRZI_BIT       3
`define NPX_EC_INV_CODE_BIT   2
`define NPX_EC_RSVD1_BIT      1
`define NPX_EC_SCR_DIS_BIT    0
`define NPX_RSVD_HI_RESET     4'h0
`define NPX_NRZI_RESET        1'h1

// ------------------------------------------------------------
// Strap latch timing, in clock edges after reset release
// ------------------------------------------------------------
`define NPX_STRAP_LATCH_PHASE 2'h2
`define NPX_STRAP_DONE_PHASE  2'h3

// ------------------------------------------------------------
// Forced symbol for nibbles whose translation is not given
// ------------------------------------------------------------
`define NPX_SYM_DEFAULT       5'h00

`endif

// ---- include/npx_pkg.sv ----
// Types shared by the partner page and extended control block.
package npx_pkg;

  // One received next-page code word.
  typedef struct packed {
    logic        moreFlag;
    logic        msgFlag;
    logic        ackFlag;
    logic        toggle;
    logic [10:0] code;
  } npx_page_t;

  // Control outputs to the 100 Mb/s datapath.
  typedef struct packed {
    logic scrTest;
    logic nrzi;
    logic invCode;
    logic scrDisable;
  } npx_ctrl_t;

endpackage

// ---- design/npx_invalid_code_map.sv ----
// Forced 5-bit symbol lookup used by the invalid-code transmit test.
`timescale 1ns/1ps
`include "npx_params.svh"

module npx_invalid_code_map
(
  input  wire logic [3:0] nibble,
  output logic      [4:0] symbol
);

  // Fixed lookup; combinational so the encoder sees it in the nibble's own cycle.
  always_comb
  begin
    unique case (nibble)
      4'h0: symbol = 5'h00;
      4'h1: symbol = 5'h01;
      4'h2: symbol = 5'h02;
      4'h3: symbol = 5'h03;
      4'h4: symbol = 5'h04;
      4'h5: symbol = 5'h05;
      4'h6: symbol = 5'h06;
      4'h7: symbol = 5'h07;
      4'h8: symbol = 5'h00;
      4'h9: symbol = 5'h0d;
      4'ha: symbol = 5'h0c;
      4'hb: symbol = 5'h11;
      4'hc: symbol = 5'h10;
      4'hd: symbol = 5'h19;
      4'he: symbol = 5'h18;
      4'hf: symbol = 5'h1f;
      default: symbol = `NPX_SYM_DEFAULT;
    endcase
  end

endmodule

// ---- tb/npx_regs_assertions.sv ----
// Concurrent checks on the ports of the register block.
`timescale 1ns/1ps
`include "npx_params.svh"
module npx_regs_checker
(
  input wire logic               clk,
  input wire logic               arst_n,
  input wire logic               mgmtWrite,
  input wire logic               mgmtRead,
  input wire logic [4:0]         mgmtAddr,
  input wire logic [15:0]        mgmtWdata,
  input wire logic [15:0]        mgmtRdata,
  input wire logic               mgmtRvalid,
  input wire logic               pageValid,
  input wire npx_pkg::npx_page_t pageIn,
  input wire logic               baseWordBit11,
  input wire logic               negRestart,
  input wire logic               expectedToggle,
  input wire logic               overrideProtectedBits,
  input wire logic               txErr,
  input wire logic               txForce,
  input wire npx_pkg::npx_ctrl_t datapathCtrl,
  input wire logic [4:0]         phyAddr
);
  // ------------------------------------------------------------
  // Helpers and properties
  // ------------------------------------------------------------
  logic [15:0]        lastWdata;
  npx_pkg::npx_page_t lastPage;
  logic               ecWr;
  // Delayed copies stand in for sliced sampled values, which some tools reject.
  always_ff @(posedge clk)
  begin
    lastWdata <= mgmtWdata;
    lastPage  <= pageIn;
  end
  assign ecWr = mgmtWrite && mgmtAddr == `NPX_ADDR_EXT_CTRL;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_read_answer: assert property (mgmtRead |=> mgmtRvalid) else $error("read not answered");
  a_partner_rsvd: assert property (mgmtRead && mgmtAddr == `NPX_ADDR_PARTNER_NP |=> !mgmtRdata[14])
    else $error("partner bit 14 set");
  a_ovr_set: assert property (ecWr && mgmtWdata[15] |=> overrideProtectedBits) else $error("override not set");
  a_ovr_clear: assert property (mgmtWrite && !(ecWr && mgmtWdata[15]) |=> !overrideProtectedBits)
    else $error("override not cleared");
  a_ctrl_follow: assert property (ecWr |=> datapathCtrl == {lastWdata[5], lastWdata[3], lastWdata[2], lastWdata[0]})
    else $error("control bits wrong");
  a_tx_force: assert property (txForce == (datapathCtrl.invCode && txErr)) else $error("force wrong");
  a_addr_read: assert property (mgmtRvalid && $past(mgmtAddr) == `NPX_ADDR_EXT_CTRL |-> mgmtRdata[10:6] == phyAddr)
    else $error("address bits wrong");
  a_toggle_next: assert property (pageValid && !negRestart |=> expectedToggle == !lastPage.toggle)
    else $error("toggle not alternated");
  a_first_toggle: assert property (negRestart && !pageValid |=> expectedToggle == !baseWordBit11)
    else $error("first toggle wrong");
  c_partner_read: cover property (pageValid ##1 mgmtRead && mgmtAddr == `NPX_ADDR_PARTNER_NP);
  c_override: cover property (overrideProtectedBits ##1 mgmtWrite);
  c_force: cover property (txForce);
endmodule
bind npx_regs npx_regs_checker i_chk (.*);

// ---- tb/npx_sta_model.sv ----
// Station management model driving the register port of the block.
`timescale 1ns/1ps
module npx_sta_model
(
  input  wire logic        clk,
  output logic             mgmtWrite,
  output logic             mgmtRead,
  output logic [4:0]       mgmtAddr,
  output logic [15:0]      mgmtWdata,
  input  wire logic [15:0] mgmtRdata,
  input  wire logic        mgmtRvalid
);
  // ------------------------------------------------------------
  // Bus tasks
  // ------------------------------------------------------------
  initial
  begin
    mgmtWrite = 1'h0;
    mgmtRead  = 1'h0;
    mgmtAddr  = 5'h00;
    mgmtWdata = 16'h0000;
  end
  // Reserved bits are forced to zero, since the device may act on them.
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    mgmtWrite <= 1'h1;
    mgmtAddr  <= a;
    mgmtWdata <= d & 16'h87ed;
    @(posedge clk);
    mgmtWrite <= 1'h0;
    mgmtWdata <= ~d; // Released data no longer shows the old value.
  endtask
  // The answer wait is bounded so a dead port cannot hang the run.
  task automatic rd(input logic [4:0] a, output logic [15:0] d, output logic ok);
    @(posedge clk);
    mgmtRead <= 1'h1;
    mgmtAddr <= a;
    @(posedge clk);
    mgmtRead <= 1'h0;
    ok = 1'h0;
    d = 16'h0000;
    for (int i = 0; i < 4 && !ok; i++)
    begin
      @(posedge clk);
      ok = (mgmtRvalid === 1'h1);
      d = mgmtRdata;
    end
  endtask
endmodule

// ---- tb/tb_top.sv ----
// Self-checking bench for the partner page and extended control registers.
`timescale 1ns/1ps
`include "npx_params.svh"
module tb_top;
  // ------------------------------------------------------------
  // Signals and helpers
  // ------------------------------------------------------------
  logic clk = 1'h0, arst_n = 1'h0, mWr, mRd, rvalid, pageValid = 1'h0, base = 1'h0, negRestart = 1'h0;
  logic expTog, ovr, txErr = 1'h0, txForce;
  logic [4:0] mAddr, txSym, phyAddr, strap = 5'h15;
  logic [3:0] txNibble = 4'h0;
  logic [15:0] mWdata, rdata, last;
  npx_pkg::npx_page_t pageIn = '0;
  npx_pkg::npx_ctrl_t dpCtrl;
  logic [14:0] words [4] = '{15'h7fff, 15'h0000, 15'h5555, 15'h2aaa};
  logic [4:0] symTab [16] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07,
                              5'h00, 5'h0d, 5'h0c, 5'h11, 5'h10, 5'h19, 5'h18, 5'h1f};
  int error_cnt = 0, total_checks = 0;
  always #4 clk = ~clk;
  npx_regs i_dut (.clk(clk), .arst_n(arst_n), .mgmtWrite(mWr), .mgmtRead(mRd), .mgmtAddr(mAddr),
    .mgmtWdata(mWdata), .mgmtRdata(rdata), .mgmtRvalid(rvalid), .pageValid(pageValid), .pageIn(pageIn),
    .baseWordBit11(base), .negRestart(negRestart), .expectedToggle(expTog), .overrideProtectedBits(ovr),
    .addr4_strap_pin(strap[4]), .addr3_strap_pin(strap[3]), .addr2_strap_pin(strap[2]),
    .addr1_strap_pin(strap[1]), .addr0_strap_pin(strap[0]), .txErr(txErr), .txNibble(txNibble),
    .txForce(txForce), .txForcedSymbol(txSym), .datapathCtrl(dpCtrl), .phyAddr(phyAddr));
  npx_sta_model i_sta (.clk(clk), .mgmtWrite(mWr), .mgmtRead(mRd), .mgmtAddr(mAddr), .mgmtWdata(mWdata),
    .mgmtRdata(rdata), .mgmtRvalid(rvalid));
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    total_checks++;
    if (s !== e)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  // A read that is never answered ends the run as a failure.
  task automatic rdc(input logic [4:0] a, input logic [15:0] e);
    logic [15:0] d;
    logic ok;
    i_sta.rd(a, d, ok);
    if (!ok)
    begin
      error_cnt++;
      $display("[FAIL] read answer expected 1 seen 0");
      complete_run();
    end
    else
      chk($sformatf("reg %h", a), e, d);
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    rdc(`NPX_ADDR_EXT_CTRL, {5'h00, strap, 6'h08});
    chk("phy address", {11'h0, strap}, {11'h0, phyAddr});
    rdc(`NPX_ADDR_PARTNER_NP, 16'h0000);
    rdc(5'h1f, 16'h0000);
  endtask
  task automatic t_page();
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk);
      negRestart <= 1'h1;
      base <= i[0];
      @(posedge clk);
      negRestart <= 1'h0;
      #1 chk("first toggle", {15'h0, ~base}, {15'h0, expTog});
      @(posedge clk);
      pageValid <= 1'h1;
      pageIn <= words[i];
      @(posedge clk);
      pageValid <= 1'h0;
      #1 chk("next toggle", {15'h0, ~words[i][11]}, {15'h0, expTog});
      last = {words[i][14], 1'h0, words[i][13:0]};
      rdc(`NPX_ADDR_PARTNER_NP, last);
    end
  endtask
  // Address bits in the write data must not reach the strap copy.
  task automatic t_ctrl();
    i_sta.wr(`NPX_ADDR_EXT_CTRL, 16'h07e5);
    #1 chk("ctrl", 16'h000b, {12'h0, dpCtrl});
    chk("idle force", 16'h0000, {15'h0, txForce});
    rdc(`NPX_ADDR_EXT_CTRL, {5'h00, strap, 6'h25});
    for (int n = 0; n < 16; n++)
    begin
      @(posedge clk);
      txErr <= 1'h1;
      txNibble <= n[3:0];
      #1 chk("symbol", {10'h0, 1'h1, symTab[n]}, {10'h0, txForce, txSym});
    end
    i_sta.wr(`NPX_ADDR_EXT_CTRL, 16'h0008);
    #1 chk("no force", 16'h0004, {11'h0, txForce, dpCtrl});
  endtask
  task automatic t_override();
    i_sta.wr(`NPX_ADDR_EXT_CTRL, 16'h8008);
    rdc(`NPX_ADDR_EXT_CTRL, {5'h10, strap, 6'h08});
    chk("override", 16'h0001, {15'h0, ovr});
    i_sta.wr(`NPX_ADDR_PARTNER_NP, 16'h1234);
    #1 chk("override", 16'h0000, {15'h0, ovr});
    rdc(`NPX_ADDR_PARTNER_NP, last);
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    arst_n <= 1'h1;
    repeat (5) @(posedge clk);
    t_reset();
    t_page();
    t_ctrl();
    t_override();
    complete_run();
  end
endmodule
